/* File: hw/ac_fire_pkg.sv */
// constants and types shared by the firing-pattern generator
package ac_fire_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SETPT  = 8'h04;
  localparam logic [7:0] OFS_TBASE  = 8'h08;
  localparam logic [7:0] OFS_MINCYC = 8'h0c;
  localparam logic [7:0] OFS_RAMP   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_FIRE_LSB = 0;
  localparam int CTRL_FB_BIT   = 2;
  localparam int CTRL_DI1_LSB  = 4;
  localparam int CTRL_DI2_LSB  = 6;
  localparam int ST_EFF_LSB    = 8;
  localparam int ST_TP_LSB     = 16;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] SETPT_RST  = 32'h0000_0000;
  localparam logic [31:0] TBASE_RST  = 32'h0000_0258;
  localparam logic [31:0] MINCYC_RST = 32'h0000_0001;
  localparam logic [31:0] RAMP_RST   = 32'h0000_0000;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [6:0] PCT_FULL    = 7'h64;
  localparam logic [1:0] DI_NONE     = 2'h0;
  localparam logic [1:0] DI_ENABLE   = 2'h1;
  localparam logic [1:0] DI_PHASE    = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FIRE_TPROP, FIRE_SINGLE, FIRE_BURST, FIRE_RAMP} fire_t;
endpackage

/* File: hw/ac_load_firing_pattern.sv */
// zero-cross and phase-angle firing-pattern generator with an axi4-lite register port
`timescale 1ns/1ps

// Behaviour
// RULE1: the firing field picks time-proportioned, single, burst or ramped burst output.
// RULE2: time-proportioned output changes only at line zero crossings.
// RULE3: time-proportioned output is on for demand share of the time base, then off.
// RULE4: the time base length comes from the time-base register, in line cycles.
// RULE5: a demand of 100 percent keeps the output on without gaps.
// RULE6: contactor use turns power on while the enable input is high.
// RULE7: enable changes reach the load only at the next zero crossing.
// RULE8: in contactor use the outside controller does its own time proportioning.
// RULE9: with feedback off the loop demand input is ignored entirely.
// RULE10: the current-limit input always caps the demand, contactor use included.
// RULE11: contactor use is time-proportioned, no feedback, input one enable, set point 100.
// RULE12: single-cycle output may switch at every line cycle, at zero crossings only.
// RULE13: the count of on cycles follows the demand.
// RULE14: single-cycle gives one in four, one in two, three in four.
// RULE15: burst runs on and off last at least the minimum cycle count.
// RULE16: with four minimum cycles burst gives 4/16, 4/8 and 12/16.
// RULE17: ramped burst phase-fires the first programmed half cycles of each burst.
// RULE18: a six half-cycle ramp takes three cycles of every four-cycle burst.
// RULE19: at full demand the ramp runs once, then output stays on.
// RULE20: an input with enable role gates output; input two wins when both have it.
// RULE21: phase firing conducts the tail of each half cycle in proportion to demand.
// RULE22: an input with phase role forces phase firing while it is on.
// RULE23: on cycles are spread evenly by an accumulator stepped per block.
// RULE24: the ramp fires earlier each half cycle and ends at full conduction.
// RULE25: time-proportioned intervals are whole line cycles between zero crossings.
module ac_load_firing_pattern (
  input  wire logic        MCLK,     // system clock, 200 mhz
  input  wire logic        ARST_N,   // asynchronous reset, active low
  input  wire logic        CE,       // clock enable, freezes all state when low
  input  wire logic        ZC,       // one-cycle pulse at each line zero crossing
  input  wire logic        DIN1,     // digital input one
  input  wire logic        DIN2,     // digital input two
  input  wire logic [6:0]  LOOP_PCT, // demand from the power loop, percent
  input  wire logic [6:0]  CLIM_PCT, // ceiling from the current-limit loop, percent
  output logic             GATE_ON,  // load switch command
  input  wire logic [7:0]  AWADDR,   // write address
  input  wire logic        AWVALID,  // write address valid
  output logic             AWREADY,  // write address ready
  input  wire logic [31:0] WDATA,    // write data
  input  wire logic [3:0]  WSTRB,    // write byte strobes
  input  wire logic        WVALID,   // write data valid
  output logic             WREADY,   // write data ready
  output logic [1:0]       BRESP,    // write response
  output logic             BVALID,   // write response valid
  input  wire logic        BREADY,   // write response ready
  input  wire logic [7:0]  ARADDR,   // read address
  input  wire logic        ARVALID,  // read address valid
  output logic             ARREADY,  // read address ready
  output logic [31:0]      RDATA,    // read data
  output logic [1:0]       RRESP,    // read response
  output logic             RVALID,   // read data valid
  input  wire logic        RREADY    // read data ready
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [6:0] pct_clip(input logic [6:0] v);
    return (v > ac_fire_pkg::PCT_FULL) ? ac_fire_pkg::PCT_FULL : v;
  endfunction

  // true once cnt/per has reached num/den of the half cycle
  function automatic logic fire_due(input logic [23:0] cnt, input logic [23:0] per,
                                    input logic [8:0] num, input logic [8:0] den);
    return ({9'h0, cnt} * {24'h0, den}) >= ({9'h0, per} * {24'h0, num});
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // registers and state
  // ****************************************
  logic [31:0]        ctrl_r, setpt_r, tbase_r, mincyc_r, ramp_r;
  logic               awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]         bresp_r, rresp_r;
  logic [31:0]        rdata_r, wdata_r;
  logic [3:0]         wstrb_r;
  logic [7:0]         awaddr_r;
  logic               aw_have_r, w_have_r;
  logic               half_r, zc_on_r, gate_r, en_r, ramping_r;
  logic [15:0]        tp_cnt_r;
  logic [6:0]         acc_r;
  logic [7:0]         blk_cnt_r, ramp_k_r;
  logic [23:0]        hp_cnt_r, hp_per_r;

  ac_fire_pkg::fire_t mode;
  logic               zc_ev, cyc_ev, en_now, pa_in, pat_nxt, ramp_go, ramp_nxt, wr_go;
  logic [6:0]         dem_src, eff, acc_nxt, clim;
  logic [7:0]         minc, blk_nxt, ramp_len, sum;
  logic [15:0]        tb;
  logic [1:0]         di1_fn, di2_fn;

  assign mode     = ac_fire_pkg::fire_t'(ctrl_r[ac_fire_pkg::CTRL_FIRE_LSB +: 2]); // [RULE1]
  assign di1_fn   = ctrl_r[ac_fire_pkg::CTRL_DI1_LSB +: 2];
  assign di2_fn   = ctrl_r[ac_fire_pkg::CTRL_DI2_LSB +: 2];
  assign ramp_len = ramp_r[7:0];
  assign zc_ev    = CE && ZC;
  assign cyc_ev   = zc_ev && half_r; // a line cycle ends on every second crossing
  assign wr_go    = CE && aw_have_r && w_have_r && !bvalid_r;

  // ****************************************
  // demand, enable and override
  // ****************************************
  always_comb begin
    // loop demand is only used when feedback is on, so contactor use ignores it
    dem_src = ctrl_r[ac_fire_pkg::CTRL_FB_BIT] ? LOOP_PCT : setpt_r[6:0]; // [RULE9] [RULE11]
    clim    = pct_clip(CLIM_PCT);
    eff     = pct_clip(dem_src);
    if (clim < eff) begin
      eff = clim; // [RULE10]
    end
    en_now = 1'b1;
    if (di2_fn == ac_fire_pkg::DI_ENABLE) begin
      en_now = DIN2; // [RULE20] [RULE6]
    end else if (di1_fn == ac_fire_pkg::DI_ENABLE) begin
      en_now = DIN1; // [RULE20] [RULE6] [RULE8]
    end
    pa_in = (di1_fn == ac_fire_pkg::DI_PHASE && DIN1) ||
            (di2_fn == ac_fire_pkg::DI_PHASE && DIN2); // [RULE22]
    tb   = (tbase_r[15:0] == 16'h0) ? 16'h1 : tbase_r[15:0]; // [RULE4]
    minc = (mode == ac_fire_pkg::FIRE_SINGLE || mincyc_r[7:0] == 8'h0) ? 8'h1
         : mincyc_r[7:0]; // [RULE14]
  end

  // ****************************************
  // pattern decision at each line-cycle boundary
  // ****************************************
  always_comb begin
    pat_nxt = zc_on_r;
    acc_nxt = acc_r;
    blk_nxt = blk_cnt_r;
    ramp_go = 1'b0;
    sum     = {1'b0, acc_r} + {1'b0, eff};
    if (cyc_ev) begin
      if (mode == ac_fire_pkg::FIRE_TPROP) begin
        // the window is counted in whole line cycles of the time base
        pat_nxt = (eff == ac_fire_pkg::PCT_FULL) ||
                  (({8'h0, tp_cnt_r} * {17'h0, ac_fire_pkg::PCT_FULL}) <
                   ({17'h0, eff} * {8'h0, tb})); // [RULE3] [RULE5] [RULE25]
      end else if (blk_cnt_r == 8'h0) begin
        // one decision per block of minc cycles keeps every run at least minc long
        pat_nxt = (sum >= {1'b0, ac_fire_pkg::PCT_FULL}); // [RULE13] [RULE23] [RULE5]
        acc_nxt = pat_nxt ? 7'(sum - {1'b0, ac_fire_pkg::PCT_FULL}) : sum[6:0];
        blk_nxt = (minc > 8'h1) ? 8'h1 : 8'h0; // [RULE15] [RULE16]
        ramp_go = (mode == ac_fire_pkg::FIRE_RAMP) && pat_nxt && !zc_on_r &&
                  (ramp_len != 8'h0); // [RULE17] [RULE19]
      end else begin
        blk_nxt = ((blk_cnt_r + 8'h1) >= minc) ? 8'h0 : blk_cnt_r + 8'h1; // [RULE15]
      end
    end
    ramp_nxt = ramp_go;
    if (!ramp_go && ramping_r) begin
      ramp_nxt = zc_ev ? (((ramp_k_r + 8'h1) < ramp_len) && pat_nxt) : 1'b1; // [RULE18]
    end
  end

  // ****************************************
  // line timing
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      half_r   <= 1'b0;
      hp_cnt_r <= 24'h0;
      hp_per_r <= 24'h0;
    end else if (CE) begin
      if (ZC) begin
        half_r   <= !half_r;
        hp_per_r <= hp_cnt_r;
        hp_cnt_r <= 24'h0;
      end else if (hp_cnt_r != 24'hff_ffff) begin
        hp_cnt_r <= hp_cnt_r + 24'h1;
      end
    end
  end

  // ****************************************
  // pattern state
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tp_cnt_r  <= 16'h0;
      zc_on_r   <= 1'b0;
      acc_r     <= 7'h0;
      blk_cnt_r <= 8'h0;
      ramping_r <= 1'b0;
      ramp_k_r  <= 8'h0;
    end else if (CE) begin
      zc_on_r   <= pat_nxt;
      acc_r     <= acc_nxt;
      blk_cnt_r <= blk_nxt;
      ramping_r <= ramp_nxt;
      if (cyc_ev) begin
        tp_cnt_r <= ((tp_cnt_r + 16'h1) >= tb) ? 16'h0 : tp_cnt_r + 16'h1; // [RULE3] [RULE4]
      end
      if (ramp_go) begin
        ramp_k_r <= 8'h0;
      end else if (zc_ev && ramping_r) begin
        ramp_k_r <= ramp_k_r + 8'h1; // [RULE24]
      end
    end
  end

  // ****************************************
  // gate drive
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gate_r <= 1'b0;
      en_r   <= 1'b0;
    end else if (CE) begin
      if (ZC) begin
        en_r <= en_now; // [RULE7]
        if (pa_in) begin
          gate_r <= en_now && (eff == ac_fire_pkg::PCT_FULL); // [RULE21]
        end else if (ramp_nxt) begin
          gate_r <= 1'b0; // [RULE17]
        end else begin
          gate_r <= pat_nxt && en_now; // [RULE2] [RULE7] [RULE12] [RULE20]
        end
      end else if (!gate_r && en_r) begin
        // a thyristor latches until the next crossing, so only the turn-on is timed
        if (pa_in) begin
          gate_r <= (eff != 7'h0) && fire_due(hp_cnt_r, hp_per_r,
                    {2'h0, 7'(ac_fire_pkg::PCT_FULL - eff)},
                    {2'h0, ac_fire_pkg::PCT_FULL}); // [RULE21] [RULE22]
        end else if (ramping_r) begin
          gate_r <= fire_due(hp_cnt_r, hp_per_r, {1'b0, 8'(ramp_len - 8'h1 - ramp_k_r)},
                             {1'b0, ramp_len}); // [RULE24] [RULE17]
        end
      end
    end
  end
  assign GATE_ON = gate_r;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= ac_fire_pkg::RESP_OKAY;
    end else if (CE) begin
      if (AWVALID && awready_r) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= AWADDR;
        awready_r <= 1'b0;
      end
      if (WVALID && wready_r) begin
        w_have_r <= 1'b1;
        wdata_r  <= WDATA;
        wstrb_r  <= WSTRB;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (awaddr_r[1:0] == 2'h0 && awaddr_r <= ac_fire_pkg::OFS_STATUS)
                   ? ac_fire_pkg::RESP_OKAY : ac_fire_pkg::RESP_SLVERR;
      end
      if (bvalid_r && BREADY) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_r   <= ac_fire_pkg::CTRL_RST;
      setpt_r  <= ac_fire_pkg::SETPT_RST;
      tbase_r  <= ac_fire_pkg::TBASE_RST;
      mincyc_r <= ac_fire_pkg::MINCYC_RST;
      ramp_r   <= ac_fire_pkg::RAMP_RST;
    end else if (wr_go) begin
      case (awaddr_r)
        ac_fire_pkg::OFS_CTRL:   ctrl_r   <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_00f7;
        ac_fire_pkg::OFS_SETPT:  setpt_r  <= merge(setpt_r, wdata_r, wstrb_r) & 32'h0000_007f;
        ac_fire_pkg::OFS_TBASE:  tbase_r  <= merge(tbase_r, wdata_r, wstrb_r) & 32'h0000_ffff;
        ac_fire_pkg::OFS_MINCYC: mincyc_r <= merge(mincyc_r, wdata_r, wstrb_r) & 32'h0000_00ff;
        ac_fire_pkg::OFS_RAMP:   ramp_r   <= merge(ramp_r, wdata_r, wstrb_r) & 32'h0000_00ff;
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= ac_fire_pkg::RESP_OKAY;
    end else if (CE) begin
      if (ARVALID && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rresp_r   <= ac_fire_pkg::RESP_OKAY;
        case (ARADDR)
          ac_fire_pkg::OFS_CTRL:   rdata_r <= ctrl_r;
          ac_fire_pkg::OFS_SETPT:  rdata_r <= setpt_r;
          ac_fire_pkg::OFS_TBASE:  rdata_r <= tbase_r;
          ac_fire_pkg::OFS_MINCYC: rdata_r <= mincyc_r;
          ac_fire_pkg::OFS_RAMP:   rdata_r <= ramp_r;
          ac_fire_pkg::OFS_STATUS: begin
            rdata_r <= {tp_cnt_r, 1'b0, eff, 3'h0, ramping_r, pa_in, en_now, zc_on_r, gate_r};
          end
          default: begin
            rdata_r <= 32'h0;
            rresp_r <= ac_fire_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rvalid_r && RREADY) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign AWREADY = awready_r;
  assign WREADY  = wready_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  a_tp_zc_switch: assert property ($changed(gate_r) && $past(mode == ac_fire_pkg::FIRE_TPROP && !pa_in)
    |-> $past(zc_ev)) else $error("time-proportioned gate moved off a crossing"); // [RULE2]
  a_enable_zc: assert property (zc_ev && !en_now |=> !gate_r)
    else $error("gate on with enable low at crossing"); // [RULE7]
  a_cycle_zc: assert property ($changed(gate_r) && $past(!pa_in && !ramping_r) |-> $past(zc_ev))
    else $error("zero-cross gate moved mid-cycle"); // [RULE12]
  a_full_on: assert property (zc_ev && en_now && !pa_in && !ramp_nxt && pat_nxt |=> gate_r)
    else $error("gate off though pattern on"); // [RULE5]
  a_burst_block: assert property ($changed(zc_on_r) && $past(mode != ac_fire_pkg::FIRE_TPROP)
    |-> $past(blk_cnt_r) == 8'h0) else $error("burst pattern changed inside a block"); // [RULE15]
  a_tp_window: assert property (cyc_ev && mode == ac_fire_pkg::FIRE_TPROP && eff == 7'h0
    |=> !zc_on_r) else $error("zero demand produced an on cycle"); // [RULE3]
  a_phase_tail: assert property (zc_ev && pa_in && eff != ac_fire_pkg::PCT_FULL |=> !gate_r)
    else $error("phase gate not dropped at crossing"); // [RULE21]
  a_ramp_step: assert property (zc_ev && ramping_r && !ramp_go |=> ramp_k_r == $past(ramp_k_r) + 8'h1)
    else $error("ramp step not advanced"); // [RULE24]
  a_clim_cap: assert property (eff <= pct_clip(CLIM_PCT))
    else $error("demand above current limit"); // [RULE10]
  a_override: assert property (pa_in && zc_ev && en_now && eff == ac_fire_pkg::PCT_FULL |=> gate_r)
    else $error("override at full demand not on"); // [RULE22]
  a_bvalid_hold: assert property (bvalid_r && !BREADY |=> bvalid_r)
    else $error("write response dropped early");

  c_tp_on: cover property (mode == ac_fire_pkg::FIRE_TPROP && $rose(gate_r));
  c_ramp_start: cover property (ramp_go ##1 ramping_r [*3]);
  c_override: cover property (pa_in && $rose(gate_r));
  c_burst_run: cover property (mode == ac_fire_pkg::FIRE_BURST && $fell(zc_on_r));
endmodule

/* File: verification/line_zc_model.sv */
// ac line stand-in: zero-cross pulse source and watcher of load switch edges
`timescale 1ns/1ps
module line_zc_model #(
  parameter int HALF = 60              // clocks per half line cycle
) (
  input  wire logic MCLK,              // system clock
  input  wire logic ARST_N,            // reset, active low
  input  wire logic GATE_ON,           // load switch command
  output logic      ZC,                // one-clock pulse at each crossing
  output int        ph,                // clocks since the last crossing
  output logic      bad_edge           // gate moved away from a crossing
);
  logic gate_d;
  logic zc_d;
  // ****************************************
  // line timing
  // ****************************************
  // two crossings per line cycle, evenly spaced
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ph <= 1;
      ZC <= 1'b0;
    end else begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      ZC <= (ph == HALF - 1);
    end
  end
  // a switch edge is legal only in the cycle right after a crossing
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gate_d   <= 1'b0;
      zc_d     <= 1'b0;
      bad_edge <= 1'b0;
    end else begin
      gate_d   <= GATE_ON;
      zc_d     <= ZC;
      bad_edge <= (GATE_ON != gate_d) && !zc_d;
    end
  end
endmodule

/* File: verification/tb_ac_load_firing_pattern.sv */
// self-checking bench for the firing-pattern generator
`timescale 1ns/1ps
module tb_ac_load_firing_pattern;
  localparam int H = 60;
  logic        MCLK, ARST_N, CE, ZC, DIN1, DIN2, GATE_ON, bad_edge;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic [6:0]  LOOP_PCT, CLIM_PCT;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rr;
  logic        zc_chk, con_chk, sel2, en_q, meas;
  int          ph, seed, error_cnt, n_compared, e, l, q4, q6, k, d;

  ac_load_firing_pattern dut (.MCLK, .ARST_N, .CE, .ZC, .DIN1, .DIN2, .LOOP_PCT, .CLIM_PCT, .GATE_ON,
    .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
  line_zc_model #(.HALF(H)) line (.MCLK, .ARST_N, .GATE_ON, .ZC, .ph, .bad_edge);

  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, want %h", $time, s, x);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang(input bit stuck);
    if (stuck) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit go;
    int n;
    go = 1;
    n = 0;
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (go && n < 100) begin
      @(posedge MCLK);
      n++;
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID) begin
        BREADY <= 1'b0;
        rr = BRESP;
        go = 0;
      end
    end
    hang(go);
  endtask
  task automatic rdr(input logic [7:0] a);
    bit go;
    int n;
    go = 1;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (go && n < 100) begin
      @(posedge MCLK);
      n++;
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID) begin
        RREADY <= 1'b0;
        rd = RDATA;
        rr = RRESP;
        go = 0;
      end
    end
    hang(go);
  endtask
  // counts whole halves from a crossing; early, 43, 57 percent and late samples
  task automatic measure(input int halves);
    int n;
    n = 0;
    while (ph != 1 && n < 2 * H) begin
      @(posedge MCLK);
      n++;
    end
    hang(ph != 1);
    e = 0;
    l = 0;
    q4 = 0;
    q6 = 0;
    meas = 1'b1;
    repeat (halves * H) @(posedge MCLK);
    meas = 1'b0;
  endtask
  // settling of eight halves covers a whole four-cycle block
  task automatic cfg(input logic [31:0] c, input logic [31:0] s);
    wr(ac_fire_pkg::OFS_CTRL, c);
    wr(ac_fire_pkg::OFS_SETPT, s);
    measure(8);
  endtask

  always @(posedge MCLK) begin
    if (meas) begin
      e += (ph == 3 && GATE_ON === 1'b1);
      q4 += (ph == 26 && GATE_ON === 1'b1);
      q6 += (ph == 34 && GATE_ON === 1'b1);
      l += (ph == H - 3 && GATE_ON === 1'b1);
    end
    if (ZC) en_q <= sel2 ? DIN2 : DIN1;
    if (con_chk && ph == 30) chk(GATE_ON, en_q);
    // outside controller switching the enable at will
    if (con_chk && ph == 15) begin
      DIN1 <= 1'($random(seed));
      DIN2 <= 1'($random(seed));
    end
    if (zc_chk) chk(bad_edge, 1'b0);
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 75;
    error_cnt = 0;
    n_compared = 0;
    {CE, DIN1, DIN2, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 8'h80;
    {zc_chk, con_chk, sel2, en_q, meas} = 5'h00;
    {AWADDR, ARADDR, WDATA, LOOP_PCT} = 55'h0;
    CLIM_PCT = 7'h64;
    WSTRB = 4'hf;
    ARST_N = 1'b0;
    repeat (10) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    rdr(ac_fire_pkg::OFS_CTRL);
    chk(rd, ac_fire_pkg::CTRL_RST);
    rdr(ac_fire_pkg::OFS_TBASE);
    chk(rd, ac_fire_pkg::TBASE_RST);
    rdr(ac_fire_pkg::OFS_MINCYC);
    chk(rd, ac_fire_pkg::MINCYC_RST);
    rdr(8'h18);
    chk(32'(rr), 32'(ac_fire_pkg::RESP_SLVERR));
    chk(rd, 32'h0);
    wr(ac_fire_pkg::OFS_STATUS, 32'hffff_ffff);
    chk(rr, ac_fire_pkg::RESP_OKAY);
    wr(ac_fire_pkg::OFS_TBASE, 32'h4);
    wr(ac_fire_pkg::OFS_MINCYC, 32'h4);
    zc_chk = 1'b1;
    // time-proportioned, single and burst at 25, 50, 75 and 100 percent
    for (k = 0; k < 12; k++) begin
      cfg(k / 4, 25 * (k % 4 + 1));
      measure(32);
      chk(e, 8 * (k % 4 + 1));
      chk(l, e);
    end
    LOOP_PCT <= 7'h32;
    cfg(32'h5, 0);
    measure(32);
    chk(e, 16);
    // contactor: loop demand zero must not matter while feedback is off
    LOOP_PCT <= 7'h00;
    cfg(32'h10, 100);
    con_chk = 1'b1;
    measure(64);
    con_chk = 1'b0;
    sel2 = 1'b1;
    cfg(32'h50, 100);
    con_chk = 1'b1;
    measure(64);
    con_chk = 1'b0;
    DIN2 <= 1'b1;
    CLIM_PCT <= 7'h00;
    measure(4);
    measure(16);
    chk(l, 0);
    CLIM_PCT <= 7'h64;
    zc_chk = 1'b0;
    DIN1 <= 1'b1;
    cfg(32'h21, 50);
    measure(32);
    chk(q4, 32'd0);
    chk(q6, 32'd32);
    chk(l, 32'd32);
    wr(ac_fire_pkg::OFS_RAMP, 32'h6);
    cfg(32'h3, 25);
    measure(32);
    chk(l, 8);
    chk(32'(l - e >= 5 && l - e <= 6), 1);
    cfg(32'h3, 0);
    measure(8);
    wr(ac_fire_pkg::OFS_SETPT, 32'd100);
    measure(32);
    chk(32'(l - e >= 5 && l - e <= 6), 1);
    measure(32);
    chk(e, 32);
    wr(ac_fire_pkg::OFS_RAMP, 32'h0);
    // random demand in single-cycle mode over one hundred line cycles
    d = {$random(seed)} % 101;
    cfg(1, d);
    zc_chk = 1'b1;
    measure(200);
    chk(32'(e >= 2 * d - 2 && e <= 2 * d + 2), 1);
    close_out();
  end
endmodule
